// [rtl/agent_end.sv]
// far end: arbiter plus a second bus agent acting as initiator and target
`default_nettype none
module agent_end (
    pci_cyc_if.agt_mp bus,          // shared bus lines
    input wire logic start,         // pulse: begin an initiator transaction
    input wire logic [3:0] nphases, // data phases for start, 0 taken as 1
    input wire logic tgt_hit,       // level: address decodes to this agent
    input wire logic tgt_rdy,       // level: target side can take data
    input wire logic park_dev,      // level: park the grant on the controller
    output logic done,              // pulse: initiator transaction finished
    output logic aborted,           // pulse: no claim, transaction dropped
    output logic busy,              // initiator transaction in progress
    output logic tgt_done,          // pulse: target data phase completed
    output logic tgt_last           // pulse: completed phase was the last
);
    ////////////////////////////////////////////////////////////////////////
    pci_cyc_pkg::init_state_type ist_r, ist_nxt;
    pci_cyc_pkg::tgt_state_type tst_r, tst_nxt;
    logic [3:0] ph_r, ph_nxt, to_r, to_nxt;
    logic own_r, own_nxt, gnt_n_r, gnt_n_nxt;
    logic done_r, done_nxt, ab_r, ab_nxt, busy_r, busy_nxt;
    logic fo_r, fo_nxt, foe_r, foe_nxt, io_r, io_nxt;
    logic fprev_r, tdone_r, tdone_nxt, tlast_r, tlast_nxt;
    logic dso_r, dso_nxt, tro_r, tro_nxt, toe_r, toe_nxt;
    logic bus_idle, phase_ok;

    assign bus_idle = bus.frame_n & bus.irdy_n;
    assign phase_ok = ~bus.irdy_n & ~bus.trdy_n;

    always_comb begin
        ist_nxt = ist_r;
        ph_nxt = ph_r;
        to_nxt = to_r;
        done_nxt = 1'b0;
        ab_nxt = 1'b0;
        unique case (ist_r)
            pci_cyc_pkg::I_IDLE: begin
                if (start) begin
                    ist_nxt = pci_cyc_pkg::I_WAIT;
                    ph_nxt = (nphases == pci_cyc_pkg::CNT_RST) ? pci_cyc_pkg::PH_ONE : nphases;
                end
            end
            pci_cyc_pkg::I_WAIT: begin
                if (own_r && bus_idle) begin
                    ist_nxt = pci_cyc_pkg::I_ADDR;
                end
            end
            pci_cyc_pkg::I_ADDR: begin
                ist_nxt = pci_cyc_pkg::I_DATA;
                to_nxt = pci_cyc_pkg::CNT_RST;
            end
            pci_cyc_pkg::I_DATA: begin
                if (bus.devsel_n && to_r != pci_cyc_pkg::DEVSEL_WAIT_CYC) begin
                    to_nxt = to_r + pci_cyc_pkg::PH_ONE;
                    if (to_nxt == pci_cyc_pkg::DEVSEL_WAIT_CYC) begin
                        ist_nxt = pci_cyc_pkg::I_ABORT;
                    end
                end else if (!bus.devsel_n) begin
                    to_nxt = pci_cyc_pkg::DEVSEL_WAIT_CYC;
                    if (phase_ok) begin
                        if (ph_r == pci_cyc_pkg::PH_ONE) begin
                            ist_nxt = pci_cyc_pkg::I_TURN;
                            done_nxt = 1'b1;
                        end else begin
                            ph_nxt = ph_r - pci_cyc_pkg::PH_ONE;
                        end
                    end
                end
            end
            pci_cyc_pkg::I_ABORT: begin
                ist_nxt = pci_cyc_pkg::I_TURN;
                ab_nxt = 1'b1;
            end
            pci_cyc_pkg::I_TURN: begin
                ist_nxt = pci_cyc_pkg::I_IDLE;
            end
            default: begin
                ist_nxt = pci_cyc_pkg::I_IDLE;
            end
        endcase
        // own grant only after the controller's grant has been off a cycle
        own_nxt = (ist_r != pci_cyc_pkg::I_IDLE) && (own_r || (bus.req_n && gnt_n_r));
        // parking yields once this agent wants the bus, else it would never get it
        gnt_n_nxt = ~((~bus.req_n | (park_dev & (ist_r == pci_cyc_pkg::I_IDLE))) &
            ~own_r & ~own_nxt);
        busy_nxt = (ist_nxt != pci_cyc_pkg::I_IDLE);
        fo_nxt = ~((ist_nxt == pci_cyc_pkg::I_ADDR) ||
            ((ist_nxt == pci_cyc_pkg::I_DATA) && (ph_nxt != pci_cyc_pkg::PH_ONE))); // R05 R06 R07
        foe_nxt = (ist_nxt != pci_cyc_pkg::I_IDLE) && (ist_nxt != pci_cyc_pkg::I_WAIT); // R04
        io_nxt = ~((ist_nxt == pci_cyc_pkg::I_DATA) || (ist_nxt == pci_cyc_pkg::I_ABORT));
    end

    always_comb begin
        tst_nxt = tst_r;
        tdone_nxt = 1'b0;
        tlast_nxt = 1'b0;
        unique case (tst_r)
            pci_cyc_pkg::T_IDLE: begin
                if (fprev_r && !bus.frame_n && !foe_r && tgt_hit) begin // R05
                    tst_nxt = pci_cyc_pkg::T_CLAIM;
                end
            end
            pci_cyc_pkg::T_CLAIM: begin
                if (phase_ok) begin // R10
                    tdone_nxt = 1'b1;
                    if (bus.frame_n) begin
                        tst_nxt = pci_cyc_pkg::T_TURN; // R07
                        tlast_nxt = 1'b1;
                    end
                end
            end
            pci_cyc_pkg::T_TURN: begin
                tst_nxt = pci_cyc_pkg::T_IDLE;
            end
            default: begin
                tst_nxt = pci_cyc_pkg::T_IDLE;
            end
        endcase
        dso_nxt = ~(tst_nxt == pci_cyc_pkg::T_CLAIM);
        tro_nxt = ~((tst_nxt == pci_cyc_pkg::T_CLAIM) && tgt_rdy);
        toe_nxt = (tst_nxt != pci_cyc_pkg::T_IDLE);
    end

    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            ist_r <= pci_cyc_pkg::I_IDLE;
            tst_r <= pci_cyc_pkg::T_IDLE;
            ph_r <= pci_cyc_pkg::CNT_RST;
            to_r <= pci_cyc_pkg::CNT_RST;
            own_r <= pci_cyc_pkg::FLAG_RST;
            gnt_n_r <= pci_cyc_pkg::LINE_RST;
            done_r <= pci_cyc_pkg::FLAG_RST;
            ab_r <= pci_cyc_pkg::FLAG_RST;
            busy_r <= pci_cyc_pkg::FLAG_RST;
            fo_r <= pci_cyc_pkg::LINE_RST;
            foe_r <= pci_cyc_pkg::OE_RST;
            io_r <= pci_cyc_pkg::LINE_RST;
            fprev_r <= pci_cyc_pkg::LINE_RST;
            tdone_r <= pci_cyc_pkg::FLAG_RST;
            tlast_r <= pci_cyc_pkg::FLAG_RST;
            dso_r <= pci_cyc_pkg::LINE_RST;
            tro_r <= pci_cyc_pkg::LINE_RST;
            toe_r <= pci_cyc_pkg::OE_RST;
        end else begin
            ist_r <= ist_nxt;
            tst_r <= tst_nxt;
            ph_r <= ph_nxt;
            to_r <= to_nxt;
            own_r <= own_nxt;
            gnt_n_r <= gnt_n_nxt;
            done_r <= done_nxt;
            ab_r <= ab_nxt;
            busy_r <= busy_nxt;
            fo_r <= fo_nxt;
            foe_r <= foe_nxt;
            io_r <= io_nxt;
            fprev_r <= bus.frame_n;
            tdone_r <= tdone_nxt;
            tlast_r <= tlast_nxt;
            dso_r <= dso_nxt;
            tro_r <= tro_nxt;
            toe_r <= toe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign bus.agt_frame_o = fo_r;
    assign bus.agt_frame_oe = foe_r;
    assign bus.agt_irdy_o = io_r;
    assign bus.agt_irdy_oe = foe_r;
    assign bus.agt_devsel_o = dso_r;
    assign bus.agt_devsel_oe = toe_r;
    assign bus.agt_trdy_o = tro_r;
    assign bus.agt_trdy_oe = toe_r;
    assign bus.gnt_n = gnt_n_r;
    assign done = done_r;
    assign aborted = ab_r;
    assign busy = busy_r;
    assign tgt_done = tdone_r;
    assign tgt_last = tlast_r;
endmodule : agent_end
`default_nettype wire

// [rtl/ctrl_end.sv]
// controller end: bus initiator with claim timeout, and bus target
// What this block does
// R01: assert device select to claim addressed cycles
// R02: as initiator, watch device select until claimed
// R03: no claim before timeout: initiator abort
// R04: only the initiator drives the frame line
// R05: frame assertion starts a new transaction
// R06: frame held while more data phases follow
// R07: frame released marks the final data phase
// R08: granted start waits for bus idle
// R09: grant without request accepted as parking
// R10: phase completes when both readies sampled
// R11: each initiator abort sets a sticky flag
`default_nettype none
module ctrl_end (
    pci_cyc_if.dev_mp bus,          // shared bus lines
    input wire logic start,         // pulse: begin an initiator transaction
    input wire logic [3:0] nphases, // data phases for start, 0 taken as 1
    input wire logic tgt_hit,       // level: address decodes to this end
    input wire logic tgt_rdy,       // level: target side can take data
    input wire logic abort_clr,     // pulse: clear abort_flag
    output logic done,              // pulse: initiator transaction finished
    output logic aborted,           // pulse: initiator abort performed
    output logic abort_flag,        // sticky initiator abort status
    output logic parked,            // bus parked here while idle
    output logic busy,              // initiator transaction in progress
    output logic tgt_done,          // pulse: target data phase completed
    output logic tgt_last           // pulse: completed phase was the last
);
    ////////////////////////////////////////////////////////////////////////
    pci_cyc_pkg::init_state_type ist_r, ist_nxt;
    logic [3:0] ph_r, ph_nxt;
    logic [3:0] to_r, to_nxt;
    logic seen_r, seen_nxt;
    logic done_r, done_nxt;
    logic aborted_r, aborted_nxt;
    logic flag_r, flag_nxt;
    logic parked_r, parked_nxt;
    logic busy_r, busy_nxt;
    logic frame_o_r, frame_o_nxt, frame_oe_r, frame_oe_nxt;
    logic irdy_o_r, irdy_o_nxt, irdy_oe_r, irdy_oe_nxt;
    logic req_n_r, req_n_nxt;
    logic bus_idle, phase_ok;

    assign bus_idle = bus.frame_n & bus.irdy_n;
    assign phase_ok = ~bus.irdy_n & ~bus.trdy_n; // R10

    always_comb begin
        ist_nxt = ist_r;
        ph_nxt = ph_r;
        to_nxt = to_r;
        seen_nxt = seen_r;
        done_nxt = 1'b0;
        aborted_nxt = 1'b0;
        unique case (ist_r)
            pci_cyc_pkg::I_IDLE: begin
                if (start) begin
                    ist_nxt = pci_cyc_pkg::I_WAIT;
                    ph_nxt = (nphases == pci_cyc_pkg::CNT_RST) ? pci_cyc_pkg::PH_ONE : nphases;
                end
            end
            pci_cyc_pkg::I_WAIT: begin
                // a parked grant also serves here, no new request edge is needed
                if (!bus.gnt_n && bus_idle) begin // R08 R09
                    ist_nxt = pci_cyc_pkg::I_ADDR;
                end
            end
            pci_cyc_pkg::I_ADDR: begin
                ist_nxt = pci_cyc_pkg::I_DATA;
                to_nxt = pci_cyc_pkg::CNT_RST;
                seen_nxt = 1'b0;
            end
            pci_cyc_pkg::I_DATA: begin
                if (!bus.devsel_n) begin
                    seen_nxt = 1'b1; // R02
                end
                if (!seen_r && bus.devsel_n) begin
                    if (to_r == pci_cyc_pkg::DEVSEL_WAIT_CYC - pci_cyc_pkg::PH_ONE) begin
                        ist_nxt = pci_cyc_pkg::I_ABORT; // R03
                    end else begin
                        to_nxt = to_r + pci_cyc_pkg::PH_ONE; // R02
                    end
                end else if (phase_ok) begin // R10
                    if (ph_r == pci_cyc_pkg::PH_ONE) begin
                        ist_nxt = pci_cyc_pkg::I_TURN;
                        done_nxt = 1'b1;
                    end else begin
                        ph_nxt = ph_r - pci_cyc_pkg::PH_ONE;
                    end
                end
            end
            pci_cyc_pkg::I_ABORT: begin
                ist_nxt = pci_cyc_pkg::I_TURN;
                aborted_nxt = 1'b1; // R03
            end
            pci_cyc_pkg::I_TURN: begin
                ist_nxt = pci_cyc_pkg::I_IDLE;
            end
            default: begin
                ist_nxt = pci_cyc_pkg::I_IDLE;
            end
        endcase
        // new abort wins over a clear in the same cycle
        flag_nxt = aborted_nxt | (flag_r & ~abort_clr); // R11
        parked_nxt = (ist_nxt == pci_cyc_pkg::I_IDLE) & ~bus.gnt_n & bus_idle; // R09
        busy_nxt = (ist_nxt != pci_cyc_pkg::I_IDLE);
        req_n_nxt = (ist_nxt != pci_cyc_pkg::I_WAIT);
        // frame low in address phase and every data phase but the last
        frame_o_nxt = ~((ist_nxt == pci_cyc_pkg::I_ADDR) ||
            ((ist_nxt == pci_cyc_pkg::I_DATA) && (ph_nxt != pci_cyc_pkg::PH_ONE))); // R05 R06 R07
        frame_oe_nxt = (ist_nxt != pci_cyc_pkg::I_IDLE) &&
            (ist_nxt != pci_cyc_pkg::I_WAIT); // R04
        irdy_o_nxt = ~((ist_nxt == pci_cyc_pkg::I_DATA) || (ist_nxt == pci_cyc_pkg::I_ABORT));
        irdy_oe_nxt = frame_oe_nxt;
    end

    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            ist_r <= pci_cyc_pkg::I_IDLE;
            ph_r <= pci_cyc_pkg::CNT_RST;
            to_r <= pci_cyc_pkg::CNT_RST;
            seen_r <= pci_cyc_pkg::FLAG_RST;
            done_r <= pci_cyc_pkg::FLAG_RST;
            aborted_r <= pci_cyc_pkg::FLAG_RST;
            flag_r <= pci_cyc_pkg::FLAG_RST;
            parked_r <= pci_cyc_pkg::FLAG_RST;
            busy_r <= pci_cyc_pkg::FLAG_RST;
            req_n_r <= pci_cyc_pkg::LINE_RST;
            frame_o_r <= pci_cyc_pkg::LINE_RST;
            frame_oe_r <= pci_cyc_pkg::OE_RST;
            irdy_o_r <= pci_cyc_pkg::LINE_RST;
            irdy_oe_r <= pci_cyc_pkg::OE_RST;
        end else begin
            ist_r <= ist_nxt;
            ph_r <= ph_nxt;
            to_r <= to_nxt;
            seen_r <= seen_nxt;
            done_r <= done_nxt;
            aborted_r <= aborted_nxt;
            flag_r <= flag_nxt;
            parked_r <= parked_nxt;
            busy_r <= busy_nxt;
            req_n_r <= req_n_nxt;
            frame_o_r <= frame_o_nxt;
            frame_oe_r <= frame_oe_nxt;
            irdy_o_r <= irdy_o_nxt;
            irdy_oe_r <= irdy_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    pci_cyc_pkg::tgt_state_type tst_r, tst_nxt;
    logic fprev_r;
    logic tdone_r, tdone_nxt;
    logic tlast_r, tlast_nxt;
    logic devsel_o_r, devsel_o_nxt, trdy_o_r, trdy_o_nxt, tgt_oe_r, tgt_oe_nxt;
    logic new_txn;

    // own cycles are not decoded: the frame we drive is never a foreign start
    assign new_txn = fprev_r & ~bus.frame_n & ~frame_oe_r; // R05

    always_comb begin
        tst_nxt = tst_r;
        tdone_nxt = 1'b0;
        tlast_nxt = 1'b0;
        unique case (tst_r)
            pci_cyc_pkg::T_IDLE: begin
                if (new_txn && tgt_hit) begin
                    tst_nxt = pci_cyc_pkg::T_CLAIM; // R01
                end
            end
            pci_cyc_pkg::T_CLAIM: begin
                if (phase_ok) begin // R10
                    tdone_nxt = 1'b1;
                    if (bus.frame_n) begin
                        tst_nxt = pci_cyc_pkg::T_TURN; // R07
                        tlast_nxt = 1'b1;
                    end
                end
            end
            pci_cyc_pkg::T_TURN: begin
                tst_nxt = pci_cyc_pkg::T_IDLE;
            end
            default: begin
                tst_nxt = pci_cyc_pkg::T_IDLE;
            end
        endcase
        devsel_o_nxt = ~(tst_nxt == pci_cyc_pkg::T_CLAIM); // R01
        trdy_o_nxt = ~((tst_nxt == pci_cyc_pkg::T_CLAIM) && tgt_rdy);
        tgt_oe_nxt = (tst_nxt != pci_cyc_pkg::T_IDLE);
    end

    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            tst_r <= pci_cyc_pkg::T_IDLE;
            fprev_r <= pci_cyc_pkg::LINE_RST;
            tdone_r <= pci_cyc_pkg::FLAG_RST;
            tlast_r <= pci_cyc_pkg::FLAG_RST;
            devsel_o_r <= pci_cyc_pkg::LINE_RST;
            trdy_o_r <= pci_cyc_pkg::LINE_RST;
            tgt_oe_r <= pci_cyc_pkg::OE_RST;
        end else begin
            tst_r <= tst_nxt;
            fprev_r <= bus.frame_n;
            tdone_r <= tdone_nxt;
            tlast_r <= tlast_nxt;
            devsel_o_r <= devsel_o_nxt;
            trdy_o_r <= trdy_o_nxt;
            tgt_oe_r <= tgt_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign bus.dev_frame_o = frame_o_r;
    assign bus.dev_frame_oe = frame_oe_r;
    assign bus.dev_irdy_o = irdy_o_r;
    assign bus.dev_irdy_oe = irdy_oe_r;
    assign bus.dev_devsel_o = devsel_o_r;
    assign bus.dev_devsel_oe = tgt_oe_r;
    assign bus.dev_trdy_o = trdy_o_r;
    assign bus.dev_trdy_oe = tgt_oe_r;
    assign bus.req_n = req_n_r;
    assign done = done_r;
    assign aborted = aborted_r;
    assign abort_flag = flag_r;
    assign parked = parked_r;
    assign busy = busy_r;
    assign tgt_done = tdone_r;
    assign tgt_last = tlast_r;
endmodule : ctrl_end
`default_nettype wire

// [rtl/pci_cyc_if.sv]
// shared bus lines between the controller end and the far agent/arbiter end
`default_nettype none
interface pci_cyc_if (
    input wire logic clk, // bus clock
    input wire logic rst  // async reset, active high
);
    logic dev_frame_o, dev_frame_oe, agt_frame_o, agt_frame_oe, frame_n;
    logic dev_irdy_o, dev_irdy_oe, agt_irdy_o, agt_irdy_oe, irdy_n;
    logic dev_trdy_o, dev_trdy_oe, agt_trdy_o, agt_trdy_oe, trdy_n;
    logic dev_devsel_o, dev_devsel_oe, agt_devsel_o, agt_devsel_oe, devsel_n;
    logic req_n;
    logic gnt_n;
    // wired lines with pull-ups: any enabled low driver wins
    assign frame_n = (dev_frame_oe ? dev_frame_o : 1'b1) & (agt_frame_oe ? agt_frame_o : 1'b1);
    assign irdy_n = (dev_irdy_oe ? dev_irdy_o : 1'b1) & (agt_irdy_oe ? agt_irdy_o : 1'b1);
    assign trdy_n = (dev_trdy_oe ? dev_trdy_o : 1'b1) & (agt_trdy_oe ? agt_trdy_o : 1'b1);
    assign devsel_n = (dev_devsel_oe ? dev_devsel_o : 1'b1) &
        (agt_devsel_oe ? agt_devsel_o : 1'b1);
    modport dev_mp (
        input clk, rst, frame_n, irdy_n, trdy_n, devsel_n, gnt_n,
        output dev_frame_o, dev_frame_oe, dev_irdy_o, dev_irdy_oe,
        output dev_trdy_o, dev_trdy_oe, dev_devsel_o, dev_devsel_oe, req_n
    );
    modport agt_mp (
        input clk, rst, frame_n, irdy_n, trdy_n, devsel_n, req_n,
        output agt_frame_o, agt_frame_oe, agt_irdy_o, agt_irdy_oe,
        output agt_trdy_o, agt_trdy_oe, agt_devsel_o, agt_devsel_oe, gnt_n
    );
endinterface : pci_cyc_if
`default_nettype wire

// [rtl/pci_cyc_pkg.sv]
// shared constants and state types for the bus cycle control ends
`default_nettype none
package pci_cyc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    // window in which some target must claim after the address phase
    localparam int unsigned DEVSEL_WAIT_NS = 20;
    localparam int unsigned DEVSEL_WAIT_CYC_I = (DEVSEL_WAIT_NS / CLK_PERIOD_NS < 1) ? 1 :
        DEVSEL_WAIT_NS / CLK_PERIOD_NS;
    localparam logic [3:0] DEVSEL_WAIT_CYC = 4'(DEVSEL_WAIT_CYC_I);
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] PH_ONE = 4'h1;
    // bus lines idle high through the pull-ups
    localparam logic LINE_RST = 1'b1;
    localparam logic OE_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    typedef enum logic [5:0] {
        I_IDLE = 6'h01,
        I_WAIT = 6'h02,
        I_ADDR = 6'h04,
        I_DATA = 6'h08,
        I_ABORT = 6'h10,
        I_TURN = 6'h20
    } init_state_type;
    typedef enum logic [2:0] {
        T_IDLE = 3'h1,
        T_CLAIM = 3'h2,
        T_TURN = 3'h4
    } tgt_state_type;
endpackage : pci_cyc_pkg
`default_nettype wire

// [test/pci_cyc_sva.sv]
// concurrent checks on the shared bus cycle lines
`default_nettype none
module pci_cyc_sva (
    input wire logic clk,           // bus clock
    input wire logic rst,           // async reset, active high
    input wire logic dev_frame_o,   // controller frame level
    input wire logic dev_frame_oe,  // controller frame enable
    input wire logic agt_frame_oe,  // agent frame enable
    input wire logic dev_irdy_o,    // controller irdy level
    input wire logic dev_irdy_oe,   // controller irdy enable
    input wire logic agt_irdy_oe,   // agent irdy enable
    input wire logic dev_devsel_o,  // controller devsel level
    input wire logic dev_devsel_oe, // controller devsel enable
    input wire logic frame_n,       // resolved frame
    input wire logic irdy_n,        // resolved irdy
    input wire logic trdy_n,        // resolved trdy
    input wire logic devsel_n,      // resolved devsel
    input wire logic gnt_n          // grant to controller
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_frame_one_drv: assert property (!(dev_frame_oe && agt_frame_oe))
        else $error("frame driven by both ends");
    chk_irdy_one_drv: assert property (!(dev_irdy_oe && agt_irdy_oe))
        else $error("irdy driven by both ends");
    chk_start_on_grant: assert property ($rose(dev_frame_oe) |->
        $past(!gnt_n && frame_n && irdy_n))
        else $error("controller started without grant on idle bus");
    chk_claim_after_frame: assert property ($rose(dev_devsel_oe) |->
        !dev_devsel_o && $past(!frame_n && !dev_frame_oe) && $past(frame_n, 2))
        else $error("claim not one cycle after frame fell");
    // the window may close on either of two edges, so the abort gets a small range
    chk_claim_timeout: assert property ($rose(dev_frame_oe) ##1 devsel_n [*5] |->
        ##[0:2] (frame_n && !irdy_n))
        else $error("unclaimed transaction not aborted");
    chk_last_phase_irdy: assert property ($rose(frame_n) && (dev_frame_oe || agt_frame_oe)
        |-> !irdy_n)
        else $error("frame released without irdy on last phase");
    chk_frame_wait_hold: assert property ((dev_frame_oe && !frame_n && !irdy_n
        && !devsel_n && trdy_n) |=> !frame_n)
        else $error("frame dropped during wait state");
    chk_devsel_hold: assert property ((dev_devsel_oe && !devsel_n &&
        !(frame_n && !irdy_n && !trdy_n)) |=> !devsel_n)
        else $error("devsel released before final phase completed");
    chk_turn_high: assert property ($fell(dev_frame_oe) |->
        $past(dev_frame_o) && $past(dev_irdy_o))
        else $error("frame or irdy not driven high before release");
endmodule : pci_cyc_sva
`default_nettype wire

// [test/pci_cycle_control_signals_tb.sv]
// testbench joining controller end and agent end across the bus lines
`default_nettype none
module pci_cycle_control_signals_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic c_start = 1'b0, c_hit = 1'b0, c_rdy = 1'b1, c_clr = 1'b0;
    logic a_start = 1'b0, a_hit = 1'b0, a_rdy = 1'b1, a_park = 1'b0;
    logic [3:0] nph = 4'h1;
    logic c_done, c_ab, c_flag, c_park, c_busy, c_tgd, c_tgl;
    logic a_done, a_ab, a_busy, a_tgd, a_tgl;
    int n_errors = 0;
    int n_tests = 0;
    int cnt[8];
    always #2 clk = ~clk;
    pci_cyc_if i_pci_cyc_if (.clk(clk), .rst(rst));
    ctrl_end i_ctrl_end (.bus(i_pci_cyc_if.dev_mp), .start(c_start), .nphases(nph),
        .tgt_hit(c_hit), .tgt_rdy(c_rdy), .abort_clr(c_clr), .done(c_done), .aborted(c_ab),
        .abort_flag(c_flag), .parked(c_park), .busy(c_busy), .tgt_done(c_tgd),
        .tgt_last(c_tgl));
    agent_end i_agent_end (.bus(i_pci_cyc_if.agt_mp), .start(a_start), .nphases(nph),
        .tgt_hit(a_hit), .tgt_rdy(a_rdy), .park_dev(a_park), .done(a_done), .aborted(a_ab),
        .busy(a_busy), .tgt_done(a_tgd), .tgt_last(a_tgl));
    pci_cyc_sva i_pci_cyc_sva (.clk(clk), .rst(rst), .dev_frame_o(i_pci_cyc_if.dev_frame_o),
        .dev_frame_oe(i_pci_cyc_if.dev_frame_oe), .agt_frame_oe(i_pci_cyc_if.agt_frame_oe),
        .dev_irdy_o(i_pci_cyc_if.dev_irdy_o), .dev_irdy_oe(i_pci_cyc_if.dev_irdy_oe),
        .agt_irdy_oe(i_pci_cyc_if.agt_irdy_oe), .dev_devsel_o(i_pci_cyc_if.dev_devsel_o),
        .dev_devsel_oe(i_pci_cyc_if.dev_devsel_oe), .frame_n(i_pci_cyc_if.frame_n),
        .irdy_n(i_pci_cyc_if.irdy_n), .trdy_n(i_pci_cyc_if.trdy_n),
        .devsel_n(i_pci_cyc_if.devsel_n), .gnt_n(i_pci_cyc_if.gnt_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask : chk_bit
    task automatic chk_cnt(input int exp[8]);
        for (int j = 0; j < 8; j++) begin
            n_tests++;
            if (cnt[j] != exp[j]) begin
                n_errors++;
                $display("ERROR %0t pulse count %0d: got %0d want %0d", $time, j, cnt[j], exp[j]);
            end
        end
    endtask : chk_cnt
    // pulses counted per output; the run ends once both initiators are idle again
    task automatic go(input logic cs, input logic as, input logic [3:0] n, input int rdy_at,
        input int exp[8]);
        logic [7:0] pv;
        int k;
        @(posedge clk);
        c_start <= cs;
        a_start <= as;
        nph <= n;
        @(posedge clk);
        c_start <= 1'b0;
        a_start <= 1'b0;
        cnt = '{default: 0};
        for (k = 0; k < 100; k++) begin
            @(posedge clk);
            if (k == rdy_at) a_rdy <= 1'b1;
            #1;
            pv = {c_done, c_ab, a_done, a_ab, c_tgd, c_tgl, a_tgd, a_tgl};
            for (int j = 0; j < 8; j++) if (pv[7 - j] === 1'b1) cnt[j]++;
            if (k > 3 && c_busy === 1'b0 && a_busy === 1'b0) break;
        end
        if (k == 100) begin
            n_errors++;
            $display("ERROR %0t transaction never finished", $time);
            close_out();
        end else begin
            chk_cnt(exp);
        end
    endtask : go
    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_xfer();
        @(posedge clk);
        a_hit <= 1'b1;
        go(1'b1, 1'b0, 4'h3, -1, '{1, 0, 0, 0, 0, 0, 3, 1});
        go(1'b1, 1'b0, 4'h0, -1, '{1, 0, 0, 0, 0, 0, 1, 1});
    endtask : sc_xfer
    task automatic sc_wait();
        @(posedge clk);
        a_rdy <= 1'b0;
        go(1'b1, 1'b0, 4'h2, 8, '{1, 0, 0, 0, 0, 0, 2, 1});
    endtask : sc_wait
    task automatic sc_abort();
        @(posedge clk);
        a_hit <= 1'b0;
        go(1'b1, 1'b0, 4'h4, -1, '{0, 1, 0, 0, 0, 0, 0, 0});
        chk_bit(c_flag, 1'b1, "abort flag set");
        @(posedge clk);
        c_clr <= 1'b1;
        @(posedge clk);
        c_clr <= 1'b0;
        @(posedge clk);
        #1;
        chk_bit(c_flag, 1'b0, "abort flag cleared");
        go(1'b0, 1'b1, 4'h2, -1, '{0, 0, 0, 1, 0, 0, 0, 0});
    endtask : sc_abort
    task automatic sc_agent();
        @(posedge clk);
        c_hit <= 1'b1;
        go(1'b0, 1'b1, 4'h2, -1, '{0, 0, 1, 0, 2, 1, 0, 0});
        @(posedge clk);
        a_hit <= 1'b1;
        // both ask at once: one must wait for the other to finish
        go(1'b1, 1'b1, 4'h1, -1, '{1, 0, 1, 0, 1, 1, 1, 1});
    endtask : sc_agent
    task automatic sc_park();
        int k;
        @(posedge clk);
        a_park <= 1'b1;
        // look after the edge has settled, except the first look, which falls in the edge's own time step
        for (k = 0; k < 20 && c_park !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk_bit(c_park, 1'b1, "parked without request");
        go(1'b1, 1'b0, 4'h1, -1, '{1, 0, 0, 0, 0, 0, 1, 1});
        @(posedge clk);
        a_park <= 1'b0;
    endtask : sc_park
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        sc_xfer();
        sc_wait();
        sc_abort();
        sc_agent();
        sc_park();
        close_out();
    end
endmodule : pci_cycle_control_signals_tb
`default_nettype wire
